// ===== src/tsnap_map.vh
`ifndef TSNAP_MAP_VH
`define TSNAP_MAP_VH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define TSNAP_GPS_SUB_OFS 17'h00200
`define TSNAP_GPS_SEC_OFS 17'h00204
`define TSNAP_CAB_SUB_OFS 17'h00210
`define TSNAP_CAB_SEC_OFS 17'h00214
`define TSNAP_CAB_MST_OFS 17'h00220
`define TSNAP_IRIG_SUB_OFS 17'h00230
`define TSNAP_IRIG_SEC_OFS 17'h00234
`define TSNAP_ERR_CLR_OFS 17'h00400
`define TSNAP_OUT_STAT_OFS 17'h00410
`define TSNAP_IN_STAT_OFS 17'h00420
`define TSNAP_IRQ_STAT_OFS 17'h00440
`define TSNAP_IRQ_MASK_OFS 17'h00444
`define TSNAP_TICK_HI_OFS 17'h01000
`define TSNAP_TICK_LO_OFS 17'h01008
`define TSNAP_TICK_CS_OFS 17'h01010
`define TSNAP_WALL_SEC_OFS 17'h01100
`define TSNAP_WALL_NS_OFS 17'h01108
`define TSNAP_ALIAS_BASE 17'h10000
`define TSNAP_LOW_BASE 17'h01000
// ----------------------------------------
// Fields and counts
// ----------------------------------------
`define TSNAP_SUB_SEC_LSB 30
`define TSNAP_TICK_RUN_BIT 0
`define TSNAP_NS_PER_SEC 32'd1000000000
`define TSNAP_CLK_NS 32'd40
`define TSNAP_TICK_CS_RST 32'h00000001
// Interrupt status bits
`define TSNAP_IRQ_GPS 0
`define TSNAP_IRQ_IRIG 1
`define TSNAP_IRQ_CAB 2
`define TSNAP_IRQ_ERR 3
`define TSNAP_IRQ_W 4
`define TSNAP_RESP_OKAY 2'b00
`define TSNAP_RESP_SLVERR 2'b10
`endif

// ===== src/tsnap_top.v
`timescale 1ns/1ns
`include "tsnap_map.vh"
module tsnap_top #(
	parameter ERR_W = 8
) (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// AXI4-Lite write
	input wire [16:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read
	input wire [16:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Timing events
	input wire gps_pulse,
	input wire irig_pulse,
	// Cable side
	input wire cable_time_valid,
	input wire [31:0] cable_time_seconds,
	input wire [ERR_W-1:0] in_cable_err,
	input wire [ERR_W-1:0] out_cable_err,
	// Interrupt
	output reg irq
);
	// ----------------------------------------
	// Wall clock and tick clock state
	// ----------------------------------------
	reg [31:0] sec_q;
	reg [31:0] sec_d;
	reg [31:0] ns_q;
	reg [31:0] ns_d;
	reg [63:0] tick_q;
	reg [63:0] tick_d;
	reg [31:0] tick_cs_q;
	wire tick_run;
	wire [31:0] ns_next;
	wire ns_wrap;
	wire [31:0] sub_word;
	assign tick_run = tick_cs_q[`TSNAP_TICK_RUN_BIT];
	assign ns_next = ns_q + `TSNAP_CLK_NS;
	assign ns_wrap = ns_next >= `TSNAP_NS_PER_SEC;
	// Two seconds bits above thirty nanosecond bits
	assign sub_word = {sec_q[1:0], ns_q[29:0]};
	// ----------------------------------------
	// Snapshot, cable and interrupt state
	// ----------------------------------------
	reg [31:0] gps_sub_q;
	reg [31:0] gps_sec_q;
	reg [31:0] cab_sub_q;
	reg [31:0] cab_sec_q;
	reg [31:0] irig_sub_q;
	reg [31:0] irig_sec_q;
	reg [31:0] cab_mst_q;
	reg [ERR_W-1:0] in_err_q;
	reg [ERR_W-1:0] out_err_q;
	reg [`TSNAP_IRQ_W-1:0] irq_stat_q;
	reg [`TSNAP_IRQ_W-1:0] irq_mask_q;
	wire err_now;
	wire [`TSNAP_IRQ_W-1:0] ev;
	assign err_now = (|in_cable_err) | (|out_cable_err);
	assign ev = {err_now, cable_time_valid, irig_pulse, gps_pulse};
	// ----------------------------------------
	// Write channel state and decode
	// ----------------------------------------
	reg aw_have_q;
	reg w_have_q;
	reg [16:0] aw_addr_q;
	reg [31:0] w_data_q;
	wire aw_take;
	wire w_take;
	wire wr_go;
	wire wr_alias_ok;
	wire [16:0] wa;
	wire wr_err_clr;
	wire wr_sec;
	wire wr_ns;
	wire wr_thi;
	wire wr_tlo;
	wire wr_tcs;
	wire wr_ist;
	wire wr_imk;
	wire wr_known;
	assign aw_take = s_axi_awvalid && s_axi_awready;
	assign w_take = s_axi_wvalid && s_axi_wready;
	assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
	// Page 0x10xxx mirrors clock page 0x01xxx
	assign wr_alias_ok = (aw_addr_q[16:12] == 5'h10) || (aw_addr_q[16:12] == 5'h01);
	assign wa = {5'h01, aw_addr_q[11:0]};
	assign wr_err_clr = wr_go && (aw_addr_q == `TSNAP_ERR_CLR_OFS);
	assign wr_sec = wr_go && wr_alias_ok && (wa == `TSNAP_WALL_SEC_OFS);
	assign wr_ns = wr_go && wr_alias_ok && (wa == `TSNAP_WALL_NS_OFS);
	assign wr_thi = wr_go && wr_alias_ok && (wa == `TSNAP_TICK_HI_OFS);
	assign wr_tlo = wr_go && wr_alias_ok && (wa == `TSNAP_TICK_LO_OFS);
	assign wr_tcs = wr_go && wr_alias_ok && (wa == `TSNAP_TICK_CS_OFS);
	assign wr_ist = wr_go && (aw_addr_q == `TSNAP_IRQ_STAT_OFS);
	assign wr_imk = wr_go && (aw_addr_q == `TSNAP_IRQ_MASK_OFS);
	assign wr_known = wr_err_clr | wr_sec | wr_ns | wr_thi | wr_tlo | wr_tcs | wr_ist | wr_imk;
	// ----------------------------------------
	// Write channel handshakes
	// ----------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
		end else begin
			s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
		end
	end
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			aw_addr_q <= 17'h00000;
		end else if (aw_take) begin
			aw_have_q <= 1'b1;
			aw_addr_q <= s_axi_awaddr;
		end else if (wr_go) begin
			aw_have_q <= 1'b0;
		end
	end
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_wready <= !w_have_q && !s_axi_wready && s_axi_wvalid;
		end
	end
	always @(posedge aclk) begin
		if (!aresetn) begin
			w_have_q <= 1'b0;
			w_data_q <= 32'h00000000;
		end else if (w_take) begin
			w_have_q <= 1'b1;
			w_data_q <= s_axi_wdata;
		end else if (wr_go) begin
			w_have_q <= 1'b0;
		end
	end
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `TSNAP_RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_known ? `TSNAP_RESP_OKAY : `TSNAP_RESP_SLVERR;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end
	// ----------------------------------------
	// Wall clock
	// ----------------------------------------
	always @* begin
		sec_d = sec_q;
		ns_d = ns_next;
		if (ns_wrap) begin
			ns_d = ns_next - `TSNAP_NS_PER_SEC;
			sec_d = sec_q + 32'h00000001;
		end
		if (wr_sec)
			sec_d = w_data_q;
		if (wr_ns) begin
			if (w_data_q < `TSNAP_NS_PER_SEC)
				ns_d = w_data_q;
			else
				ns_d = 32'h00000000;
		end
	end
	always @(posedge aclk) begin
		if (!aresetn) begin
			sec_q <= 32'h00000000;
			ns_q <= 32'h00000000;
		end else begin
			sec_q <= sec_d;
			ns_q <= ns_d;
		end
	end
	// ----------------------------------------
	// Tick clock
	// ----------------------------------------
	always @* begin
		tick_d = tick_q;
		if (tick_run)
			tick_d = tick_q + 64'h0000000000000001;
		if (wr_thi)
			tick_d[63:32] = w_data_q;
		if (wr_tlo)
			tick_d[31:0] = w_data_q;
	end
	always @(posedge aclk) begin
		if (!aresetn) begin
			tick_q <= 64'h0000000000000000;
		end else begin
			tick_q <= tick_d;
		end
	end
	always @(posedge aclk) begin
		if (!aresetn) begin
			tick_cs_q <= `TSNAP_TICK_CS_RST;
		end else if (wr_tcs) begin
			tick_cs_q <= w_data_q;
		end
	end
	// ----------------------------------------
	// Event snapshots
	// ----------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			gps_sub_q <= 32'h00000000;
			gps_sec_q <= 32'h00000000;
		end else if (gps_pulse) begin
			gps_sub_q <= sub_word;
			gps_sec_q <= sec_q;
		end
	end
	always @(posedge aclk) begin
		if (!aresetn) begin
			cab_sub_q <= 32'h00000000;
			cab_sec_q <= 32'h00000000;
		end else if (cable_time_valid) begin
			cab_sub_q <= sub_word;
			cab_sec_q <= sec_q;
		end
	end
	always @(posedge aclk) begin
		if (!aresetn) begin
			cab_mst_q <= 32'h00000000;
		end else if (cable_time_valid) begin
			cab_mst_q <= cable_time_seconds;
		end
	end
	always @(posedge aclk) begin
		if (!aresetn) begin
			irig_sub_q <= 32'h00000000;
			irig_sec_q <= 32'h00000000;
		end else if (irig_pulse) begin
			irig_sub_q <= sub_word;
			irig_sec_q <= sec_q;
		end
	end
	// ----------------------------------------
	// Cable errors
	// ----------------------------------------
	// Errors stick; new error wins over clear
	always @(posedge aclk) begin
		if (!aresetn) begin
			in_err_q <= {ERR_W{1'b0}};
		end else begin
			in_err_q <= (wr_err_clr ? {ERR_W{1'b0}} : in_err_q) | in_cable_err;
		end
	end
	always @(posedge aclk) begin
		if (!aresetn) begin
			out_err_q <= {ERR_W{1'b0}};
		end else begin
			out_err_q <= (wr_err_clr ? {ERR_W{1'b0}} : out_err_q) | out_cable_err;
		end
	end
	// ----------------------------------------
	// Interrupts
	// ----------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_q <= {`TSNAP_IRQ_W{1'b0}};
		end else begin
			irq_stat_q <= (wr_ist ? irq_stat_q & ~w_data_q[`TSNAP_IRQ_W-1:0] : irq_stat_q) | ev;
		end
	end
	always @(posedge aclk) begin
		if (!aresetn) begin
			irq_mask_q <= {`TSNAP_IRQ_W{1'b0}};
		end else if (wr_imk) begin
			irq_mask_q <= w_data_q[`TSNAP_IRQ_W-1:0];
		end
	end
	always @(posedge aclk) begin
		if (!aresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat_q & irq_mask_q);
		end
	end
	// ----------------------------------------
	// Read channel
	// ----------------------------------------
	wire rd_alias_ok;
	wire [16:0] ra;
	reg [31:0] rd_d;
	reg rd_ok;
	// Page 0x10xxx mirrors clock page 0x01xxx
	assign rd_alias_ok = (s_axi_araddr[16:12] == 5'h10) || (s_axi_araddr[16:12] == 5'h01);
	assign ra = {5'h01, s_axi_araddr[11:0]};
	always @* begin
		rd_d = 32'h00000000;
		rd_ok = 1'b1;
		if (rd_alias_ok) begin
			case (ra)
				`TSNAP_TICK_HI_OFS: rd_d = tick_q[63:32];
				`TSNAP_TICK_LO_OFS: rd_d = tick_q[31:0];
				`TSNAP_TICK_CS_OFS: rd_d = tick_cs_q;
				`TSNAP_WALL_SEC_OFS: rd_d = sec_q;
				`TSNAP_WALL_NS_OFS: rd_d = ns_q;
				default: rd_ok = 1'b0;
			endcase
		end else begin
			case (s_axi_araddr)
				`TSNAP_GPS_SUB_OFS: rd_d = gps_sub_q;
				`TSNAP_GPS_SEC_OFS: rd_d = gps_sec_q;
				`TSNAP_CAB_SUB_OFS: rd_d = cab_sub_q;
				`TSNAP_CAB_SEC_OFS: rd_d = cab_sec_q;
				`TSNAP_CAB_MST_OFS: rd_d = cab_mst_q;
				`TSNAP_IRIG_SUB_OFS: rd_d = irig_sub_q;
				`TSNAP_IRIG_SEC_OFS: rd_d = irig_sec_q;
				`TSNAP_OUT_STAT_OFS: rd_d = {{(32-ERR_W){1'b0}}, out_err_q};
				`TSNAP_IN_STAT_OFS: rd_d = {{(32-ERR_W){1'b0}}, in_err_q};
				`TSNAP_IRQ_STAT_OFS: rd_d = {{(32-`TSNAP_IRQ_W){1'b0}}, irq_stat_q};
				`TSNAP_IRQ_MASK_OFS: rd_d = {{(32-`TSNAP_IRQ_W){1'b0}}, irq_mask_q};
				default: rd_ok = 1'b0;
			endcase
		end
	end
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `TSNAP_RESP_OKAY;
		end else begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_d;
				s_axi_rresp <= rd_ok ? `TSNAP_RESP_OKAY : `TSNAP_RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule // tsnap_top

// ===== verif/tscr_cable_peer.sv
`timescale 1ns/1ns
module tscr_cable_peer (
	// Commands
	input wire aclk,
	input wire send,
	input wire [31:0] secs,
	input wire [7:0] ein,
	input wire [7:0] eout,
	// Cable
	output logic cable_time_valid = 0,
	output logic [31:0] cable_time_seconds = 0,
	output logic [7:0] in_cable_err = 0,
	output logic [7:0] out_cable_err = 0
);
	always @(posedge aclk) begin
		cable_time_valid <= send;
		cable_time_seconds <= send ? secs : ~cable_time_seconds;
		in_cable_err <= ein;
		out_cable_err <= eout;
	end
endmodule // tscr_cable_peer

// ===== verif/tscr_monitor.sv
`timescale 1ns/1ns
`include "tsnap_map.vh"
module tscr_monitor (
	// Bus and cable
	input wire aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
	input wire s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
	input wire [1:0] s_axi_bresp, s_axi_rresp,
	input wire [16:0] s_axi_araddr,
	input wire [31:0] s_axi_rdata, cable_time_seconds,
	input wire cable_time_valid
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	reg [16:0] ra_q;
	reg [31:0] mst_q;
	always @(posedge aclk) begin
		if (s_axi_arvalid && s_axi_arready) ra_q <= s_axi_araddr;
		if (!aresetn) mst_q <= 32'h0;
		else if (cable_time_valid) mst_q <= cable_time_seconds;
	end
	sequence ar_taken; s_axi_arvalid && s_axi_arready; endsequence
	sequence mst_answer; s_axi_rvalid && ra_q == `TSNAP_CAB_MST_OFS; endsequence
	a_aw_ready_pulse: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready) else $error("awready held");
	a_w_ready_pulse: assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready) else $error("wready held");
	a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_b_follows: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:3] s_axi_bvalid) else $error("no write response");
	a_r_next: assert property (ar_taken |=> s_axi_rvalid) else $error("read answer late");
	a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_err_data_zero: assert property (s_axi_rvalid && s_axi_rresp == `TSNAP_RESP_SLVERR |-> s_axi_rdata == 0)
		else $error("error read data not zero");
	a_master_time: assert property (ar_taken ##1 mst_answer |-> s_axi_rdata == mst_q)
		else $error("master seconds wrong");
endmodule // tscr_monitor
bind tsnap_top tscr_monitor mon (.*);

// ===== verif/test_time_snapshot_clock_regs.sv
`timescale 1ns/1ns
`include "tsnap_map.vh"
module test_time_snapshot_clock_regs;
	logic aclk = 0, aresetn = 0, gps_pulse = 0, irig_pulse = 0, send = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic [16:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, secs = 0, d, a;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [7:0] ein = 0, eout = 0;
	logic [1:0] r;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, cable_time_valid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata, cable_time_seconds;
	wire [7:0] in_cable_err, out_cable_err;
	integer error_cnt = 0, cmp_count = 0, n;
	logic [16:0] ofs[5] = '{`TSNAP_TICK_HI_OFS, `TSNAP_TICK_LO_OFS, `TSNAP_TICK_CS_OFS,
		`TSNAP_WALL_SEC_OFS, `TSNAP_WALL_NS_OFS};
	logic [31:0] ex[5] = '{32'h0, 32'h0, `TSNAP_TICK_CS_RST, 32'h7, 32'h0};
	tsnap_top uut (.*);
	tscr_cable_peer peer (.*);
	always #20 aclk = ~aclk;
	task report_and_stop;
		$display("Compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %0t: got %h want %h", $time, g, e);
		end
	endtask
	task tick;
		@(posedge aclk);
		n++;
		if (n > 99) begin
			error_cnt++;
			$display("Error %0t: timeout", $time);
			report_and_stop;
		end
	endtask
	// ----------------------------------------
	// Bus cycles
	// ----------------------------------------
	task wr(input logic [16:0] ad, input logic [31:0] wd);
		logic pa, pw;
		@(posedge aclk);
		s_axi_awaddr <= ad;
		s_axi_wdata <= wd;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		pa = 1;
		pw = 1;
		n = 0;
		while (pa || pw) begin
			tick;
			if (pa && s_axi_awready) begin
				s_axi_awvalid <= 0;
				pa = 0;
			end
			if (pw && s_axi_wready) begin
				s_axi_wvalid <= 0;
				pw = 0;
			end
		end
		while (!s_axi_bvalid) tick;
		s_axi_bready <= 1;
		tick;
		r = s_axi_bresp;
		s_axi_bready <= 0;
	endtask
	task rd(input logic [16:0] ad);
		@(posedge aclk);
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1;
		n = 0;
		do tick; while (!s_axi_arready);
		s_axi_arvalid <= 0;
		while (!s_axi_rvalid) tick;
		s_axi_rready <= 1;
		tick;
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 0;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_bad;
		rd(17'h00300);
		chk({30'h0, r}, {30'h0, `TSNAP_RESP_SLVERR});
		chk(d, 32'h0);
		wr(17'h00300, 32'h1);
		chk({30'h0, r}, {30'h0, `TSNAP_RESP_SLVERR});
		$display("unmapped done");
	endtask
	task t_snap(input integer k, input logic [16:0] b);
		wr(`TSNAP_WALL_SEC_OFS, 32'h5 + k);
		rd(`TSNAP_WALL_NS_OFS);
		a = d;
		@(posedge aclk);
		secs <= 32'hc0de;
		if (k == 0) gps_pulse <= 1;
		else if (k == 1) send <= 1;
		else irig_pulse <= 1;
		@(posedge aclk);
		gps_pulse <= 0;
		irig_pulse <= 0;
		send <= 0;
		rd(b + 17'h4);
		chk(d, 32'h5 + k);
		rd(b);
		chk({30'h0, d[31:30]}, (32'h5 + k) & 32'h3);
		a = d - a;
		chk({31'h0, a[29:0] > 0 && a[29:0] < 800 && a[29:0] % 40 == 0}, 1);
		if (k == 1) begin
			rd(`TSNAP_CAB_MST_OFS);
			chk(d, 32'hc0de);
		end
		$display("snapshot %0d done", k);
	endtask
	task t_alias;
		for (integer i = 0; i < 5; i++) begin
			rd(ofs[i]);
			a = d;
			rd(ofs[i] - `TSNAP_LOW_BASE + `TSNAP_ALIAS_BASE);
			if (i == 1 || i == 4) chk({31'h0, d > a}, 1);
			else begin
				chk(a, ex[i]);
				chk(d, ex[i]);
			end
		end
		$display("alias done");
	endtask
	task t_err;
		wr(`TSNAP_IRQ_MASK_OFS, 32'h0);
		wr(`TSNAP_IRQ_STAT_OFS, 32'hf);
		@(posedge aclk);
		ein <= 8'h5a;
		eout <= 8'ha5;
		@(posedge aclk);
		ein <= 0;
		eout <= 0;
		rd(`TSNAP_IN_STAT_OFS);
		chk(d, 32'h5a);
		rd(`TSNAP_OUT_STAT_OFS);
		chk(d, 32'ha5);
		rd(`TSNAP_IRQ_STAT_OFS);
		chk(d, 32'h8);
		chk({31'h0, irq}, 0);
		wr(`TSNAP_IRQ_MASK_OFS, 32'h8);
		repeat (2) @(posedge aclk);
		chk({31'h0, irq}, 1);
		wr(`TSNAP_ERR_CLR_OFS, 32'h0);
		rd(`TSNAP_IN_STAT_OFS);
		chk(d, 32'h0);
		rd(`TSNAP_OUT_STAT_OFS);
		chk(d, 32'h0);
		wr(`TSNAP_IRQ_STAT_OFS, 32'h8);
		repeat (2) @(posedge aclk);
		chk({31'h0, irq}, 0);
		$display("errors done");
	endtask
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1;
		t_bad;
		t_snap(0, `TSNAP_GPS_SUB_OFS);
		t_snap(1, `TSNAP_CAB_SUB_OFS);
		t_snap(2, `TSNAP_IRIG_SUB_OFS);
		t_alias;
		t_err;
		report_and_stop;
	end
endmodule // test_time_snapshot_clock_regs
